// file: hw/psc_map.svh
// constants for the panel setup mode controller: timing, offsets, limits
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
// clock in hertz and times in milliseconds, cycle counts derived from them
`define PSC_CLK_HZ 40000000
`define PSC_CLK_KHZ (`PSC_CLK_HZ / 1000)
`define PSC_DEBOUNCE_MS 10
`define PSC_DEBOUNCE_CYC (`PSC_DEBOUNCE_MS * `PSC_CLK_KHZ)
`define PSC_BEEP_MS 100
`define PSC_BEEP_CYC (`PSC_BEEP_MS * `PSC_CLK_KHZ)
`define PSC_BLINK_MS 125
`define PSC_BLINK_CYC (`PSC_BLINK_MS * `PSC_CLK_KHZ)
`define PSC_G3_DELAY_MS 2000
`define PSC_G3_DELAY_CYC (`PSC_G3_DELAY_MS * `PSC_CLK_KHZ)
`define PSC_G3_IDLE_MS 5000
`define PSC_G3_IDLE_CYC (`PSC_G3_IDLE_MS * `PSC_CLK_KHZ)
// register byte offsets
`define PSC_REG_STATUS 12'h000
`define PSC_REG_GROUP1 12'h004
`define PSC_REG_TABLES 12'h008
`define PSC_REG_POWERON 12'h00c
`define PSC_REG_PAGELEN 12'h010
// menu limits and table ranges
`define PSC_G1_LAST 3'h6
`define PSC_NAT_LAST 4'he
`define PSC_ALT_LAST 2'h3
`define PSC_CP_FIRST 4'h8
`define PSC_CP_LAST 4'hc
// beep counts
`define PSC_BEEPS_ONE 3'h1
`define PSC_BEEPS_TWO 3'h2
`define PSC_BEEPS_FIVE 3'h5
// factory image: every group one setting shown with the ready led off
`define PSC_NV_FACTORY 33'h0_0000_0000
`endif

// file: hw/psc_pkg.sv
// types shared by the panel setup mode controller modules
package psc_pkg;
	typedef enum logic [2:0] {
		MD_INIT = 3'h0, MD_G3WAIT = 3'h1, MD_G3 = 3'h3, MD_READY = 3'h2,
		MD_G1 = 3'h6, MD_G2 = 3'h7, MD_SELFTEST = 3'h5, MD_DUMP = 3'h4
	} psc_mode_e;
	// led code: off, on, blink, fast blink
	typedef logic [1:0] psc_led_t;
	typedef struct packed {logic font; logic pause; logic feed;} psc_btn_s;
	typedef struct packed {logic font; logic cond; logic ready;} psc_ledpin_s;
	typedef struct packed {
		logic emul; logic pitch; logic [1:0] plen; logic skip;
		logic zero; logic tear; logic autolf;
	} psc_g1_s;
	typedef struct packed {logic buf_en; logic draft_hi; logic auto_cr;} psc_pwr_s;
	typedef struct packed {
		logic [1:0][7:0] plen; psc_pwr_s pwr; logic [1:0] tab_alt;
		logic [3:0] tab_nat; psc_g1_s g1;
	} psc_nv_s;
	typedef struct packed {logic valid; logic bin; logic [7:0] lines;} psc_sheet_s;
	typedef struct packed {logic valid; logic [7:0] data;} psc_byte_s;
	typedef struct packed {logic valid; logic [15:0] hex; logic [7:0] chr;} psc_dump_s;
	typedef struct packed {logic s1; logic s2; logic lvl; logic press; logic [19:0] cnt;}
		psc_deb_s;
	typedef struct packed {logic beep; logic [3:0] left; logic [22:0] cnt;} psc_bz_s;
	typedef struct packed {
		psc_mode_e mode; logic [2:0] param; psc_nv_s nv; logic [27:0] tmr;
		logic [22:0] blk; logic [1:0] ph; psc_ledpin_s led; logic nv_we;
		logic beep_go; logic [2:0] beep_n; logic prt_def; logic prt_tab;
		logic prt_lines; logic cr_req; logic hi_pr; psc_dump_s dump;
		logic pan_font; logic pan_feed; logic pready; logic pslverr;
		logic [31:0] prdata;
	} psc_st_s;
endpackage : psc_pkg

// file: hw/psc_debounce.sv
// button synchroniser and debouncer with one pulse per press
module psc_debounce #(
	parameter int unsigned DEB_CYC = 400000
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// raw pin and clean outputs
	input wire logic i_pin,
	output logic o_level,
	output logic o_press
);
	import psc_pkg::*;
	localparam logic [19:0] LIM = 20'(DEB_CYC - 1);
	psc_deb_s q, d;

	// level only follows after it has been stable for the whole window
	always_comb begin
		d = q;
		d.s1 = i_pin;
		d.s2 = q.s1;
		d.press = 1'b0;
		if (q.s2 != q.lvl) begin
			d.cnt = q.cnt + 20'h1;
			if (q.cnt == LIM) begin
				d.lvl = q.s2;
				d.press = q.s2;
				d.cnt = '0;
			end
		end else begin
			d.cnt = '0;
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_level = q.lvl;
	assign o_press = q.press;
endmodule : psc_debounce

// file: hw/psc_beeper.sv
// buzzer sequencer: n beeps of one period each, one period apart
module psc_beeper #(
	parameter int unsigned BEEP_CYC = 4000000
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// request
	input wire logic i_go,
	input wire logic [2:0] i_count,
	// buzzer drive and status
	output logic o_beep,
	output logic o_busy
);
	import psc_pkg::*;
	localparam logic [22:0] LIM = 23'(BEEP_CYC - 1);
	psc_bz_s q, d;

	// a new request restarts the pattern, so a late confirm is never merged
	always_comb begin
		d = q;
		if (i_go && i_count != 3'h0) begin
			d.beep = 1'b1;
			d.left = 4'({i_count, 1'b0} - 4'h1);
			d.cnt = '0;
		end else if (q.cnt == LIM) begin
			d.cnt = '0;
			if (q.left != 4'h0) begin
				d.left = q.left - 4'h1;
				d.beep = ~q.beep;
			end else begin
				d.beep = 1'b0;
			end
		end else begin
			d.cnt = q.cnt + 23'h1;
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_beep = q.beep;
	assign o_busy = q.beep | (q.left != 4'h0);
endmodule : psc_beeper

// file: hw/psc_panel_ctrl.sv
// front-panel setup mode controller with apb register access
`include "psc_map.svh"

// Overview of operation
// - font held: defaults menu, beep, print
// - font press selects next group one parameter
// - pause press steps value, ready led shows
// - after last parameter wrap to first
// - commit selections to nonvolatile image
// - factory value is ready led off
// - font+pause held: table menu, beep, print
// - font press selects next table, three leds
// - native code page table makes 80-9f printable
// - alternate table one control, two printable
// - separate table selection per emulation
// - pause+feed held: power-on settings toggles
// - auto cr: line feed returns to margin
// - idle timeout: five beeps, store, leave
// - leave settings menu into ready state
// - feed held: self-test, panel still works
// - self-test stores measured sheet line count
// - separate page length per feeder bin
// - pause held: hexadecimal dump mode
// - nonprintable dump byte shown as period
// - initialization loads settings from image
module psc_panel_ctrl #(
	parameter int unsigned DEB_CYC = `PSC_DEBOUNCE_CYC,
	parameter int unsigned BEEP_CYC = `PSC_BEEP_CYC,
	parameter int unsigned BLINK_CYC = `PSC_BLINK_CYC,
	parameter int unsigned DELAY_CYC = `PSC_G3_DELAY_CYC,
	parameter int unsigned IDLE_CYC = `PSC_G3_IDLE_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// operator panel
	input wire psc_pkg::psc_btn_s i_btn,
	output psc_pkg::psc_ledpin_s o_led,
	output logic o_beep,
	// nonvolatile image
	input wire psc_pkg::psc_nv_s i_nv_image,
	input wire logic i_nv_blank,
	output psc_pkg::psc_nv_s o_nv_image,
	output logic o_nv_we,
	// print engine side
	input wire logic i_lf_cmd,
	input wire psc_pkg::psc_sheet_s i_sheet,
	input wire psc_pkg::psc_byte_s i_rx,
	output psc_pkg::psc_mode_e o_mode,
	output logic o_cr_req,
	output logic o_hi_printable,
	output logic o_print_defaults,
	output logic o_print_table,
	output logic o_print_lines,
	output psc_pkg::psc_dump_s o_dump,
	output logic o_panel_font,
	output logic o_panel_feed
);
	import psc_pkg::*;

	localparam psc_led_t L_OFF = 2'h0;
	localparam psc_led_t L_ON = 2'h1;
	localparam psc_led_t L_BLK = 2'h2;
	localparam psc_led_t L_FST = 2'h3;
	localparam logic [27:0] SETTLE_LIM = 28'(2 * DEB_CYC);
	localparam logic [27:0] DELAY_LIM = 28'(DELAY_CYC);
	localparam logic [27:0] IDLE_LIM = 28'(IDLE_CYC);
	localparam logic [22:0] BLK_LIM = 23'(BLINK_CYC - 1);

	psc_st_s q, d;
	logic [2:0] raw, lvl, prs;
	psc_btn_s hold, press;
	logic bz_busy;
	logic bz_out;
	logic acc;
	logic [31:0] rd;
	logic rd_ok;
	logic [5:0] tab_led;

	// turn a led code into a pin level using the blink phase
	function automatic logic led_lvl(input psc_led_t c, input logic [1:0] ph);
		case (c)
			L_OFF: led_lvl = 1'b0;
			L_ON: led_lvl = 1'b1;
			L_BLK: led_lvl = ph[1];
			L_FST: led_lvl = ph[0];
			default: led_lvl = 1'b0;
		endcase
	endfunction : led_lvl

	// table index n shows as base-three digits of n+1 on font, cond, ready
	function automatic logic [5:0] tri_leds(input logic [3:0] n);
		logic [4:0] v;
		v = {1'b0, n} + 5'h1;
		tri_leds = {2'(v / 5'h9), 2'((v / 5'h3) % 5'h3), 2'(v % 5'h3)};
	endfunction : tri_leds

	// ascii of one hex digit
	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		hex_chr = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction : hex_chr

	// one debouncer for each button
	assign raw = i_btn;
	generate
		for (genvar i = 0; i < 3; i++) begin : g_deb
			psc_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
				.i_clk(i_clk),
				.i_rstn(i_rstn),
				.i_pin(raw[i]),
				.o_level(lvl[i]),
				.o_press(prs[i])
			);
		end
	endgenerate
	assign hold = lvl;
	assign press = prs;

	// buzzer pattern generator
	psc_beeper #(.BEEP_CYC(BEEP_CYC)) u_bz (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_go(q.beep_go),
		.i_count(q.beep_n),
		.o_beep(bz_out),
		.o_busy(bz_busy)
	);

	// apb read mux; an unmapped address answers with an error
	assign acc = i_psel & i_penable;
	always_comb begin
		rd = 32'h0000_0000;
		rd_ok = 1'b1;
		case (i_paddr)
			`PSC_REG_STATUS: rd = {24'h00_0000, 1'b0, q.param, bz_busy, q.mode};
			`PSC_REG_GROUP1: rd = {24'h00_0000, q.nv.g1};
			`PSC_REG_TABLES: rd = {26'h000_0000, q.nv.tab_alt, q.nv.tab_nat};
			`PSC_REG_POWERON: rd = {29'h0000_0000, q.nv.pwr};
			`PSC_REG_PAGELEN: rd = {16'h0000, q.nv.plen};
			default: rd_ok = 1'b0;
		endcase
	end

	// leds of the selected table for the active emulation
	assign tab_led = tri_leds(q.nv.g1.emul ? {2'h0, q.nv.tab_alt} : q.nv.tab_nat);

	// next state of the whole controller
	always_comb begin
		d = q;
		d.nv_we = 1'b0;
		d.beep_go = 1'b0;
		d.prt_def = 1'b0;
		d.prt_tab = 1'b0;
		d.prt_lines = 1'b0;
		d.dump.valid = 1'b0;
		d.pan_font = 1'b0;
		d.pan_feed = 1'b0;
		d.tmr = q.tmr + 28'h1;
		// shared blink phase: bit0 fast, bit1 two times slower
		if (q.blk == BLK_LIM) begin
			d.blk = '0;
			d.ph = q.ph + 2'h1;
		end else begin
			d.blk = q.blk + 23'h1;
		end
		case (q.mode)
			MD_INIT: begin
				// wait long enough for a held button to pass the debouncer
				if (q.tmr == SETTLE_LIM) begin
					d.tmr = '0;
					d.nv = i_nv_blank ? psc_nv_s'(`PSC_NV_FACTORY) : i_nv_image;
					d.beep_n = `PSC_BEEPS_ONE;
					if (hold.font && hold.pause) begin
						d.mode = MD_G2;
						d.beep_go = 1'b1;
						d.prt_tab = 1'b1;
					end else if (hold.font) begin
						d.mode = MD_G1;
						d.param = 3'h0;
						d.beep_go = 1'b1;
						d.prt_def = 1'b1;
					end else if (hold.pause && hold.feed) begin
						d.mode = MD_G3WAIT;
					end else if (hold.feed) begin
						d.mode = MD_SELFTEST;
					end else if (hold.pause) begin
						d.mode = MD_DUMP;
					end else begin
						d.mode = MD_READY;
					end
				end
			end
			MD_G1: begin
				if (press.font) begin
					d.param = (q.param == `PSC_G1_LAST) ? 3'h0 : q.param + 3'h1;
				end
				if (press.pause) begin
					d.nv_we = 1'b1;
					case (q.param)
						3'h0: d.nv.g1.emul = ~q.nv.g1.emul;
						3'h1: d.nv.g1.pitch = ~q.nv.g1.pitch;
						3'h2: d.nv.g1.plen = q.nv.g1.plen + 2'h1;
						3'h3: d.nv.g1.skip = ~q.nv.g1.skip;
						3'h4: d.nv.g1.zero = ~q.nv.g1.zero;
						3'h5: d.nv.g1.tear = ~q.nv.g1.tear;
						default: d.nv.g1.autolf = ~q.nv.g1.autolf;
					endcase
				end
			end
			MD_G2: begin
				// next table of the active emulation only
				if (press.font) begin
					d.nv_we = 1'b1;
					if (q.nv.g1.emul) begin
						d.nv.tab_alt = q.nv.tab_alt + 2'h1;
					end else begin
						d.nv.tab_nat = (q.nv.tab_nat == `PSC_NAT_LAST) ? 4'h0
							: q.nv.tab_nat + 4'h1;
					end
				end
			end
			MD_G3WAIT: begin
				// ignore buttons until the hands are off
				if (q.tmr == DELAY_LIM) begin
					d.mode = MD_G3;
					d.tmr = '0;
				end
			end
			MD_G3: begin
				// toggle and confirm with one or two beeps
				if (press.pause || press.feed || press.font) begin
					d.tmr = '0;
					d.beep_go = 1'b1;
					if (press.pause) begin
						d.nv.pwr.buf_en = ~q.nv.pwr.buf_en;
					end else if (press.feed) begin
						d.nv.pwr.draft_hi = ~q.nv.pwr.draft_hi;
					end else begin
						d.nv.pwr.auto_cr = ~q.nv.pwr.auto_cr;
					end
					d.beep_n = ((press.pause && !q.nv.pwr.buf_en)
						|| (!press.pause && press.feed && !q.nv.pwr.draft_hi)
						|| (!press.pause && !press.feed && !q.nv.pwr.auto_cr))
						? `PSC_BEEPS_TWO : `PSC_BEEPS_ONE;
				end else if (q.tmr == IDLE_LIM) begin
					d.beep_go = 1'b1;
					d.beep_n = `PSC_BEEPS_FIVE;
					d.nv_we = 1'b1;
					d.mode = MD_READY;
				end
			end
			MD_READY, MD_SELFTEST: begin
				// panel presses passed to the paper and font logic
				d.pan_font = press.font;
				d.pan_feed = press.feed;
				if (q.mode == MD_SELFTEST && i_sheet.valid) begin
					d.nv.plen[i_sheet.bin] = i_sheet.lines;
					d.nv_we = 1'b1;
					d.prt_lines = 1'b1;
				end
			end
			MD_DUMP: begin
				if (i_rx.valid) begin
					d.dump.valid = 1'b1;
					d.dump.hex = {hex_chr(i_rx.data[7:4]), hex_chr(i_rx.data[3:0])};
					d.dump.chr = (i_rx.data >= 8'h20 && i_rx.data <= 8'h7e)
						? i_rx.data : 8'h2e;
				end
			end
			default: d.mode = MD_INIT;
		endcase
		d.cr_req = i_lf_cmd & q.nv.pwr.auto_cr;
		// upper control range printable or not
		d.hi_pr = q.nv.g1.emul ? q.nv.tab_alt[0]
			: (q.nv.tab_nat >= `PSC_CP_FIRST && q.nv.tab_nat <= `PSC_CP_LAST);
		// led drive for the current mode
		d.led = '{font: 1'b0, cond: 1'b0, ready: (q.mode != MD_INIT)};
		if (q.mode == MD_G1) begin
			d.led.font = led_lvl((q.param < 3'h2) ? L_OFF : (q.param < 3'h4) ? L_ON
				: L_BLK, q.ph);
			d.led.cond = led_lvl((q.param == 3'h2 || q.param == 3'h4) ? L_OFF
				: (q.param == 3'h0 || q.param == 3'h5) ? L_ON : L_BLK, q.ph);
			// page length takes two bits, so later parameters sit one bit lower
			d.led.ready = led_lvl((q.param == 3'h2) ? q.nv.g1.plen
				: {1'b0, q.nv.g1[(q.param < 3'h2) ? 3'h7 - q.param : 3'h6 - q.param]}, q.ph);
		end else if (q.mode == MD_G2) begin
			d.led.font = led_lvl(tab_led[5:4], q.ph);
			d.led.cond = led_lvl(tab_led[3:2], q.ph);
			d.led.ready = led_lvl(tab_led[1:0], q.ph);
		end
		// apb: one wait state, read data registered with pready, write data taken at the completing edge
		d.pready = acc & ~q.pready;
		d.pslverr = acc & ~q.pready & ~rd_ok;
		if (acc && !q.pready) begin
			d.prdata = i_pwrite ? 32'h0000_0000 : rd;
		end
		// software writes are committed like panel changes
		if (acc && q.pready && i_pwrite && !q.pslverr) begin
			case (i_paddr)
				`PSC_REG_GROUP1: begin
					d.nv.g1 = i_pwdata[7:0];
					d.nv_we = 1'b1;
				end
				`PSC_REG_TABLES: begin
					d.nv.tab_alt = i_pwdata[5:4];
					if (i_pwdata[3:0] <= `PSC_NAT_LAST) begin
						d.nv.tab_nat = i_pwdata[3:0];
					end
					d.nv_we = 1'b1;
				end
				`PSC_REG_POWERON: begin
					d.nv.pwr = i_pwdata[2:0];
					d.nv_we = 1'b1;
				end
				`PSC_REG_PAGELEN: begin
					d.nv.plen = i_pwdata[15:0];
					d.nv_we = 1'b1;
				end
				default: d.pslverr = 1'b0; // status is read only; keep any panel commit
			endcase
		end
	end

	// state register; every output except o_beep is taken from it
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_prdata = q.prdata;
	assign o_pready = q.pready;
	assign o_pslverr = q.pslverr;
	assign o_led = q.led;
	assign o_beep = bz_out;
	assign o_nv_image = q.nv;
	assign o_nv_we = q.nv_we;
	assign o_mode = q.mode;
	assign o_cr_req = q.cr_req;
	assign o_hi_printable = q.hi_pr;
	assign o_print_defaults = q.prt_def;
	assign o_print_table = q.prt_tab;
	assign o_print_lines = q.prt_lines;
	assign o_dump = q.dump;
	assign o_panel_font = q.pan_font;
	assign o_panel_feed = q.pan_feed;

	property p_wrap;
		@(posedge i_clk) disable iff (!i_rstn)
		q.mode == MD_G1 && q.param == 3'h6 && press.font |=> q.param == 3'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("menu did not wrap");
	property p_adv;
		@(posedge i_clk) disable iff (!i_rstn)
		q.mode == MD_G1 && q.param < 3'h6 && press.font |=> q.param == 3'($past(q.param) + 1);
	endproperty
	a_adv: assert property (p_adv) else $error("parameter not advanced");
	property p_step;
		@(posedge i_clk) disable iff (!i_rstn)
		q.mode == MD_G1 && q.param == 3'h0 && press.pause && !acc
			|=> q.nv.g1.emul != $past(q.nv.g1.emul) && q.nv_we;
	endproperty
	a_step: assert property (p_step) else $error("value not stepped");
	property p_g1in;
		@(posedge i_clk) disable iff (!i_rstn)
		q.mode == MD_G1 && $past(q.mode) == MD_INIT |-> q.beep_go && q.beep_n == 3'h1 && q.prt_def;
	endproperty
	a_g1in: assert property (p_g1in) else $error("menu entry without beep");
	property p_cp;
		@(posedge i_clk) disable iff (!i_rstn)
		!q.nv.g1.emul && q.nv.tab_nat >= 4'h8 && q.nv.tab_nat <= 4'hc |=> q.hi_pr;
	endproperty
	a_cp: assert property (p_cp) else $error("code page not printable");
	property p_alt;
		@(posedge i_clk) disable iff (!i_rstn)
		q.nv.g1.emul && !q.nv.tab_alt[0] |=> !q.hi_pr;
	endproperty
	a_alt: assert property (p_alt) else $error("variant one not control");
	property p_idle;
		@(posedge i_clk) disable iff (!i_rstn)
		q.mode == MD_G3 && q.tmr == IDLE_LIM && prs == 3'h0
			|=> q.mode == MD_READY && q.beep_n == 3'h5 && q.beep_go ##1 q.mode == MD_READY;
	endproperty
	a_idle: assert property (p_idle) else $error("idle exit wrong");
	property p_dot;
		@(posedge i_clk) disable iff (!i_rstn)
		q.mode == MD_DUMP && i_rx.valid && i_rx.data > 8'h7e |=> q.dump.valid && q.dump.chr == 8'h2e;
	endproperty
	a_dot: assert property (p_dot) else $error("nonprintable not a period");
	property p_cr;
		@(posedge i_clk) disable iff (!i_rstn)
		i_lf_cmd && q.nv.pwr.auto_cr |=> q.cr_req;
	endproperty
	a_cr: assert property (p_cr) else $error("no carriage return");
endmodule : psc_panel_ctrl

// file: sim/psc_operator.sv
// operator panel model: bouncing push buttons and a buzzer beep counter
module psc_operator (
	// clock
	input wire logic i_clk,
	// buzzer drive from the controller
	input wire logic i_beep,
	// button pins, high while pressed
	output psc_pkg::psc_btn_s o_btn
);
	timeunit 1ns;
	timeprecision 100ps;
	import psc_pkg::*;
	int beeps = 0;
	logic beep_q = 1'b0;
	initial begin
		o_btn = '0;
	end
	// count rising edges of the buzzer, one per beep
	always @(posedge i_clk) begin
		beep_q <= i_beep;
		if (i_beep && !beep_q) begin
			beeps <= beeps + 1;
		end
	end
	task hold(input psc_btn_s b);
		@(posedge i_clk);
		o_btn <= b;
	endtask : hold
	// contacts chatter for a cycle before closing, which the debouncer must hide
	task press(input psc_btn_s b, input int len);
		@(posedge i_clk);
		o_btn <= b;
		@(posedge i_clk);
		o_btn <= '0;
		@(posedge i_clk);
		o_btn <= b;
		repeat (len) @(posedge i_clk);
		o_btn <= '0;
		repeat (len) @(posedge i_clk);
	endtask : press
endmodule : psc_operator

// file: sim/tb.sv
// self-checking bench for the panel setup mode controller
`include "psc_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import psc_pkg::*;
	localparam int DEB = 4;
	localparam int PL = 3 * DEB;
	localparam psc_btn_s B_FONT = 3'b100;
	localparam psc_btn_s B_PAUSE = 3'b010;
	localparam psc_btn_s B_FEED = 3'b001;
	logic i_clk, i_rstn, psel, pen, pwr, er, nv_blank, nv_we, lf, cr, hi, pdef, ptab, plin;
	logic pfont, pfeed, beep;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr;
	logic [7:0] pl [2];
	psc_btn_s btn;
	psc_ledpin_s led;
	psc_nv_s nv_in, nv_out;
	psc_sheet_s sheet;
	psc_byte_s rx;
	psc_mode_e mode;
	psc_dump_s dump;
	int error_cnt = 0, comparisons = 0, we_n = 0, pd_n = 0, pt_n = 0, pf_n = 0, pfd_n = 0;
	int b0, p, w;
	logic [7:0] v;
	psc_panel_ctrl #(.DEB_CYC(DEB), .BEEP_CYC(4), .BLINK_CYC(2), .DELAY_CYC(20),
		.IDLE_CYC(50)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_btn(btn), .o_led(led),
		.o_beep(beep), .i_nv_image(nv_in), .i_nv_blank(nv_blank), .o_nv_image(nv_out),
		.o_nv_we(nv_we), .i_lf_cmd(lf), .i_sheet(sheet), .i_rx(rx), .o_mode(mode),
		.o_cr_req(cr), .o_hi_printable(hi), .o_print_defaults(pdef), .o_print_table(ptab),
		.o_print_lines(plin), .o_dump(dump), .o_panel_font(pfont), .o_panel_feed(pfeed));
	psc_operator op_u (.i_clk(i_clk), .i_beep(beep), .o_btn(btn));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// tally one-cycle pulses so scenarios can count them afterwards
	always @(posedge i_clk) begin
		we_n <= we_n + nv_we;
		pd_n <= pd_n + pdef;
		pt_n <= pt_n + ptab;
		pf_n <= pf_n + pfont;
		pfd_n <= pfd_n + pfeed;
	end
	task conclude;
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one apb transfer; the request stands until pready is sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1'b1);
		chk("apb wait", 2, n);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task wmode(input psc_mode_e m);
		int n;
		n = 0;
		while (mode !== m && n < 300) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk("mode", m, mode);
	endtask : wmode
	// power-on with buttons held through reset; the mode is picked 2*DEB after reset release
	task boot(input psc_btn_s b, input logic blank);
		op_u.hold(b);
		nv_blank <= blank;
		i_rstn <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (2 * DEB + 4) @(posedge i_clk);
		op_u.hold('0);
		repeat (2 * DEB + 4) @(posedge i_clk);
	endtask : boot
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 10) ? 8'h30 + n : 8'h37 + n;
	endfunction : hx
	function automatic logic [23:0] dexp(input logic [7:0] d);
		return {hx(d[7:4]), hx(d[3:0]), (d >= 8'h20 && d <= 8'h7e) ? d : 8'h2e};
	endfunction : dexp
	// engine strobes last one cycle; the answer is registered on the next edge
	task send(input logic [7:0] d);
		@(posedge i_clk);
		rx <= '{1'b1, d};
		@(posedge i_clk);
		rx <= '0;
		#1;
		chk("dump", {1'b1, dexp(d)}, dump);
	endtask : send
	task lf_pulse(input logic e);
		@(posedge i_clk);
		lf <= 1'b1;
		@(posedge i_clk);
		lf <= 1'b0;
		#1;
		chk("cr request", e, cr);
	endtask : lf_pulse
	initial begin
		#(25 * 20000);
		error_cnt++;
		conclude();
	end
	initial begin
		{i_rstn, psel, pen, pwr, lf, nv_blank} = 6'h01;
		{paddr, pwdata, sheet, rx} = '0;
		pl = '{8'h00, 8'h00};
		void'($urandom(55));
		nv_in = {$urandom(), 1'b1};
		nv_in.tab_nat = 4'h3;
		boot('0, 1'b0);
		wmode(MD_READY);
		chk("image", nv_in, nv_out);
		apb(1'b0, 12'hff0, 32'h0000_0000);
		chk("unmapped", 33'h1_0000_0000, {er, rd});
		boot('0, 1'b1);
		wmode(MD_READY);
		chk("factory", 0, nv_out);
		lf_pulse(1'b0);
		p = pd_n;
		b0 = op_u.beeps;
		boot(B_FONT, 1'b1);
		wmode(MD_G1);
		chk("beeps", 1, op_u.beeps - b0);
		chk("print defaults", 1, pd_n - p);
		chk("leds", 3'b010, led);
		for (int i = 1; i <= 7; i++) begin
			op_u.press(B_FONT, PL);
			if (i >= 6) begin
				apb(1'b0, `PSC_REG_STATUS, 32'h0000_0000);
				chk("param", (i == 7) ? 0 : 6, rd[6:4]);
			end
		end
		w = we_n;
		op_u.press(B_PAUSE, PL);
		apb(1'b0, `PSC_REG_GROUP1, 32'h0000_0000);
		chk("group1", 32'h0000_0080, rd);
		chk("ready led", 1, led.ready);
		chk("nv write", 1, we_n > w);
		v = $urandom();
		v[1] = ~v[0];
		apb(1'b1, `PSC_REG_GROUP1, {24'h0, v});
		#1;
		chk("image g1", v, nv_out.g1);
		// walk to the last parameter, whose value sits at bit zero
		for (int i = 0; i < 6; i++) begin
			op_u.press(B_FONT, PL);
		end
		chk("autolf led", v[0], led.ready);
		p = pt_n;
		b0 = op_u.beeps;
		boot(B_FONT | B_PAUSE, 1'b1);
		wmode(MD_G2);
		chk("beeps", 1, op_u.beeps - b0);
		chk("print table", 1, pt_n - p);
		for (int i = 1; i <= 8; i++) begin
			op_u.press(B_FONT, PL);
			chk("hi printable", i == 8, hi);
		end
		apb(1'b0, `PSC_REG_TABLES, 32'h0000_0000);
		chk("tables", 32'h0000_0008, rd);
		nv_in <= psc_nv_s'(33'h0_0000_0080);
		boot(B_FONT | B_PAUSE, 1'b0);
		wmode(MD_G2);
		chk("hi printable", 0, hi);
		op_u.press(B_FONT, PL);
		chk("hi printable", 1, hi);
		chk("native kept", 0, nv_out.tab_nat);
		boot(B_PAUSE | B_FEED, 1'b1);
		wmode(MD_G3);
		b0 = op_u.beeps;
		op_u.press(B_PAUSE, PL);
		repeat (12) @(posedge i_clk);
		chk("beeps", 2, op_u.beeps - b0);
		op_u.press(B_FONT, PL);
		b0 = op_u.beeps;
		op_u.press(B_FEED, PL);
		chk("beeps", 2, op_u.beeps - b0);
		b0 = op_u.beeps;
		w = we_n;
		wmode(MD_READY);
		repeat (45) @(posedge i_clk);
		chk("beeps", 5, op_u.beeps - b0);
		chk("power on", 3'b111, nv_out.pwr);
		chk("nv write", 1, we_n > w);
		lf_pulse(1'b1);
		boot(B_FEED, 1'b1);
		wmode(MD_SELFTEST);
		p = pf_n;
		op_u.press(B_FONT, PL);
		chk("panel font", 1, pf_n - p);
		p = pfd_n;
		op_u.press(B_FEED, PL);
		chk("panel feed", 1, pfd_n - p);
		for (int i = 0; i < 2; i++) begin
			pl[i] = $urandom();
			@(posedge i_clk);
			sheet <= '{1'b1, i[0], pl[i]};
			@(posedge i_clk);
			sheet <= '0;
			#1;
			chk("print lines", 1, plin);
			apb(1'b0, `PSC_REG_PAGELEN, 32'h0000_0000);
			chk("page length", {pl[1], pl[0]}, rd);
		end
		boot(B_PAUSE, 1'b1);
		wmode(MD_DUMP);
		send(8'h1f);
		send(8'h20);
		send(8'h7e);
		send(8'h7f);
		repeat (6) send($urandom());
		conclude();
	end
endmodule : tb
